// File: common/atco_pkg.sv
package atco_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ATCO_OFS_CLK_SEL = 8'h00;
  localparam logic [7:0] ATCO_OFS_CTRL0 = 8'h04;
  localparam logic [7:0] ATCO_OFS_CTRL1 = 8'h08;
  localparam logic [7:0] ATCO_OFS_SIG_SEL = 8'h0C;
  localparam logic [7:0] ATCO_OFS_MISS_HIGH = 8'h10;
  localparam logic [7:0] ATCO_OFS_MISS_LOW = 8'h14;
  localparam logic [7:0] ATCO_OFS_PERIOD = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ATCO_CLK_SRC_BIT = 0;
  localparam int ATCO_EN_BIT = 7;
  localparam int ATCO_PS_LSB = 0;
  localparam int ATCO_PHP_BIT = 3;
  localparam int ATCO_PRP_BIT = 2;
  localparam int ATCO_MPP_BIT = 1;
  localparam int ATCO_VALID_BIT = 0;
  localparam int ATCO_SIG_SEL_W = 2;

  // ----------------------------------------------------------------
  // Reset values and timing figures
  // ----------------------------------------------------------------
  localparam logic [15:0] ATCO_MISS_RESET = 16'h0000;
  localparam logic [1:0] ATCO_EDGES_TO_VALID = 2'h3;
  localparam int ATCO_FAST_OSC_MHZ = 16;
  localparam int ATCO_PHASE_SHIFT = 4;

  // Clock source codes
  localparam logic ATCO_SRC_SYS = 1'b0;
  localparam logic ATCO_SRC_FAST = 1'b1;

  // Software configuration carried as one bundle
  typedef struct packed {
    logic clock_source_select;
    logic enable;
    logic [1:0] prescale_select;
    logic phase_clock_polarity;
    logic period_clock_polarity;
    logic missed_pulse_polarity;
    logic [ATCO_SIG_SEL_W-1:0] signal_source_select;
  } atco_cfg_t;

  // Validity tracking states
  typedef enum logic [2:0] {
    ATCO_ST_IDLE = 3'b001,
    ATCO_ST_LEARN = 3'b010,
    ATCO_ST_RUN = 3'b100
  } atco_state_t;

endpackage

// File: rtl/atco_top.sv
module atco_top
  import atco_pkg::*;
#(
  parameter int NUM_SIG = 4,
  parameter int CNT_W = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_osc_in,
  input wire logic [NUM_SIG-1:0] sig_in,
  output logic phase_clock_out,
  output logic period_clock_out,
  output logic missed_pulse_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NUM_SIG:0] raw_in;
  logic [2:0] sync_reg [NUM_SIG+1];
  logic [NUM_SIG:0] level_reg, level_next;

  // Oscillator rides as the top channel; only edges slower than clk/2 count
  assign raw_in = {fast_osc_in, sig_in};

  // Three stages per input; a change counts once stages two and three agree
  for (genvar gi = 0; gi <= NUM_SIG; gi++)
  begin : g_sync
    always_comb
    begin
      level_next[gi] = level_reg[gi];
      if (sync_reg[gi][1] == sync_reg[gi][2])
        level_next[gi] = sync_reg[gi][2];
    end
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        sync_reg[gi] <= 3'h0;
        level_reg[gi] <= 1'b0;
      end
      else
      begin
        sync_reg[gi] <= {sync_reg[gi][1:0], raw_in[gi]};
        level_reg[gi] <= level_next[gi];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  atco_cfg_t cfg_reg, cfg_next;
  logic [7:0] miss_hold_reg, miss_hold_next;
  logic [15:0] miss_delay_reg, miss_delay_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic valid;
  logic [CNT_W-1:0] period_reg;

  // Answer one cycle after setup: pready rises in the first access cycle
  always_comb
  begin
    logic setup;
    logic done;
    logic hit;
    setup = psel && !penable && !pready_reg;
    done = psel && penable && pready_reg && pwrite;
    hit = 1'b1;
    cfg_next = cfg_reg;
    miss_hold_next = miss_hold_reg;
    miss_delay_next = miss_delay_reg;
    prdata_next = prdata_reg;
    pready_next = setup;
    pslverr_next = 1'b0;
    if (setup)
    begin
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        ATCO_OFS_CLK_SEL:
          prdata_next[ATCO_CLK_SRC_BIT] = cfg_reg.clock_source_select;
        ATCO_OFS_CTRL0:
        begin
          prdata_next[ATCO_EN_BIT] = cfg_reg.enable;
          prdata_next[ATCO_PS_LSB +: 2] = cfg_reg.prescale_select;
        end
        ATCO_OFS_CTRL1:
        begin
          prdata_next[ATCO_PHP_BIT] = cfg_reg.phase_clock_polarity;
          prdata_next[ATCO_PRP_BIT] = cfg_reg.period_clock_polarity;
          prdata_next[ATCO_MPP_BIT] = cfg_reg.missed_pulse_polarity;
          prdata_next[ATCO_VALID_BIT] = valid;
        end
        ATCO_OFS_SIG_SEL:
          prdata_next[ATCO_SIG_SEL_W-1:0] = cfg_reg.signal_source_select;
        ATCO_OFS_MISS_HIGH:
          prdata_next[7:0] = miss_hold_reg;
        ATCO_OFS_MISS_LOW:
          prdata_next[7:0] = miss_delay_reg[7:0];
        ATCO_OFS_PERIOD:
          prdata_next[CNT_W-1:0] = period_reg;
        default:
          hit = 1'b0;
      endcase
      pslverr_next = !hit;
    end
    if (done)
    begin
      unique case (paddr)
        ATCO_OFS_CLK_SEL:
          cfg_next.clock_source_select = pwdata[ATCO_CLK_SRC_BIT];
        ATCO_OFS_CTRL0:
        begin
          cfg_next.enable = pwdata[ATCO_EN_BIT];
          cfg_next.prescale_select = pwdata[ATCO_PS_LSB +: 2];
        end
        ATCO_OFS_CTRL1:
        begin
          cfg_next.phase_clock_polarity = pwdata[ATCO_PHP_BIT];
          cfg_next.period_clock_polarity = pwdata[ATCO_PRP_BIT];
          cfg_next.missed_pulse_polarity = pwdata[ATCO_MPP_BIT];
        end
        ATCO_OFS_SIG_SEL:
          cfg_next.signal_source_select =
            pwdata[ATCO_SIG_SEL_W-1:0];
        ATCO_OFS_MISS_HIGH:
          miss_hold_next = pwdata[7:0];
        ATCO_OFS_MISS_LOW:
          miss_delay_next = {miss_hold_reg, pwdata[7:0]};
        default:
          cfg_next = cfg_reg;
      endcase
    end
  end

  // A write lands at the edge that samples pready high, never at setup
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_reg <= '0;
      miss_hold_reg <= ATCO_MISS_RESET[15:8];
      miss_delay_reg <= ATCO_MISS_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      miss_hold_reg <= miss_hold_next;
      miss_delay_reg <= miss_delay_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------------------------------
  // Clock source, prescaler and timer core
  // ----------------------------------------------------------------
  logic src_pulse;
  logic [2:0] ps_cnt_reg, ps_cnt_next;
  logic tick;
  logic sig_sel_level;
  logic sig_prev_reg, sig_prev_next;
  logic edge_pend_reg, edge_pend_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next, period_next;
  logic [CNT_W-1:0] phase_cnt_reg, phase_cnt_next;
  logic [1:0] edge_cnt_reg, edge_cnt_next;
  logic missed_reg, missed_next;
  logic phs_pulse_reg, phs_pulse_next;
  logic per_pulse_reg, per_pulse_next;
  atco_state_t state_reg, state_next;
  logic phs_out_reg, phs_out_next;
  logic per_out_reg, per_out_next;
  logic mis_out_reg, mis_out_next;

  // Source enable: every clk cycle, or each rising edge of the oscillator
  assign src_pulse = (cfg_reg.clock_source_select == ATCO_SRC_SYS) ? 1'b1 :
                     (level_next[NUM_SIG] && !level_reg[NUM_SIG]);
  assign sig_sel_level = level_reg[cfg_reg.signal_source_select];
  assign valid = (state_reg == ATCO_ST_RUN);

  always_comb
  begin
    logic [2:0] ps_mask;
    logic [CNT_W-1:0] diff, step;
    ps_mask = 3'((4'h1 << cfg_reg.prescale_select) - 4'h1);
    diff = cnt_reg - period_reg;
    step = period_reg >> ATCO_PHASE_SHIFT;
    ps_cnt_next = ps_cnt_reg;
    tick = 1'b0;
    sig_prev_next = sig_sel_level;
    edge_pend_next = edge_pend_reg;
    cnt_next = cnt_reg;
    period_next = period_reg;
    phase_cnt_next = phase_cnt_reg;
    edge_cnt_next = edge_cnt_reg;
    missed_next = missed_reg;
    phs_pulse_next = 1'b0;
    per_pulse_next = 1'b0;
    state_next = state_reg;
    // Divide the source enable; only a tick moves the timer
    if (src_pulse)
    begin
      if ((ps_cnt_reg & ps_mask) == ps_mask)
      begin
        ps_cnt_next = 3'h0;
        tick = 1'b1;
      end
      else
        ps_cnt_next = ps_cnt_reg + 3'h1;
    end
    if (tick)
    begin
      cnt_next = cnt_reg + 1'b1;
      phase_cnt_next = phase_cnt_reg + 1'b1;
      if (phase_cnt_reg >= step && step != '0)
      begin
        phase_cnt_next = '0;
        phs_pulse_next = 1'b1;
      end
      if ($signed(diff) == $signed(miss_delay_reg))
        missed_next = 1'b1;
      if (edge_pend_reg)
      begin
        period_next = cnt_reg;
        cnt_next = '0;
        phase_cnt_next = '0;
        missed_next = 1'b0;
        per_pulse_next = 1'b1;
        if (edge_cnt_reg != ATCO_EDGES_TO_VALID)
          edge_cnt_next = edge_cnt_reg + 2'h1;
      end
    end
    // A new edge is never lost against the tick that consumes the old one
    if (tick && edge_pend_reg)
      edge_pend_next = 1'b0;
    if (sig_sel_level && !sig_prev_reg)
      edge_pend_next = 1'b1;
    // Validity: three edges with a non-zero period, cleared on disable
    unique case (state_reg)
      ATCO_ST_IDLE:
      begin
        edge_cnt_next = 2'h0;
        if (cfg_reg.enable)
          state_next = ATCO_ST_LEARN;
      end
      ATCO_ST_LEARN:
        if (!cfg_reg.enable)
          state_next = ATCO_ST_IDLE;
        else if (edge_cnt_reg == ATCO_EDGES_TO_VALID && period_reg != '0)
          state_next = ATCO_ST_RUN;
      ATCO_ST_RUN:
        if (!cfg_reg.enable || period_reg == '0)
          state_next = ATCO_ST_IDLE;
      default:
        state_next = ATCO_ST_IDLE;
    endcase
    // Inactive level equals the polarity bit while not valid
    phs_out_next = (valid && phs_pulse_reg) ^
                   cfg_reg.phase_clock_polarity;
    per_out_next = (valid && per_pulse_reg) ^
                   cfg_reg.period_clock_polarity;
    mis_out_next = (valid && missed_reg) ^
                   cfg_reg.missed_pulse_polarity;
  end

  // Timer state registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ps_cnt_reg <= 3'h0;
      sig_prev_reg <= 1'b0;
      edge_pend_reg <= 1'b0;
      cnt_reg <= '0;
      period_reg <= '0;
      phase_cnt_reg <= '0;
      edge_cnt_reg <= 2'h0;
      missed_reg <= 1'b0;
      phs_pulse_reg <= 1'b0;
      per_pulse_reg <= 1'b0;
      state_reg <= ATCO_ST_IDLE;
      phs_out_reg <= 1'b0;
      per_out_reg <= 1'b0;
      mis_out_reg <= 1'b0;
    end
    else
    begin
      ps_cnt_reg <= ps_cnt_next;
      sig_prev_reg <= sig_prev_next;
      edge_pend_reg <= edge_pend_next;
      cnt_reg <= cnt_next;
      period_reg <= period_next;
      phase_cnt_reg <= phase_cnt_next;
      edge_cnt_reg <= edge_cnt_next;
      missed_reg <= missed_next;
      phs_pulse_reg <= phs_pulse_next;
      per_pulse_reg <= per_pulse_next;
      state_reg <= state_next;
      phs_out_reg <= phs_out_next;
      per_out_reg <= per_out_next;
      mis_out_reg <= mis_out_next;
    end
  end

  assign phase_clock_out = phs_out_reg;
  assign period_clock_out = per_out_reg;
  assign missed_pulse_out = mis_out_reg;

endmodule

// File: sim/atco_sig_model.sv
// Sensor side: four channels of tooth pulses plus the fast oscillator
module atco_sig_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic drop,
  output logic [3:0] sig,
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ns;
  int n;
  // Free running position count
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      n <= 0;
    else
      n <= n + 1;
  end
  // Channel c repeats every 64*(c+1) clocks; two-clock pulses survive
  // the sync. Oscillator is clk/8, below the clk/2 limit.
  always_comb
  begin
    for (int c = 0; c < 4; c++)
      sig[c] = !drop && (n % (64 * (c + 1))) < 2;
    osc = n[2];
  end
endmodule

// File: sim/atco_top_asserts.sv
module atco_top_asserts
  import atco_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic phase_clock_out,
  input wire logic period_clock_out,
  input wire logic missed_pulse_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pol_reg, pol_next, pold_reg, o;
  logic [7:0] hi_reg, hi_next, lo_reg, lo_next;
  logic setup, wr, rd, bad;
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;
  assign rd = pready && !pwrite;
  assign bad = paddr > ATCO_OFS_PERIOD || paddr[1:0] != 2'h0;
  assign o = {phase_clock_out, period_clock_out, missed_pulse_out};
  // Shadows of what software wrote, taken at the edge that completes it
  always_comb
  begin
    pol_next = pol_reg;
    hi_next = hi_reg;
    lo_next = lo_reg;
    if (wr && paddr == ATCO_OFS_CTRL1)
      pol_next = pwdata[3:1];
    if (wr && paddr == ATCO_OFS_MISS_HIGH)
      hi_next = pwdata[7:0];
    if (wr && paddr == ATCO_OFS_MISS_LOW)
      lo_next = pwdata[7:0];
  end
  // Delayed copy masks the cycles where idle level is still moving
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pol_reg <= 3'h0;
      pold_reg <= 3'h0;
      hi_reg <= 8'h00;
      lo_reg <= 8'h00;
    end
    else
    begin
      pol_reg <= pol_next;
      pold_reg <= pol_reg;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_SETUP_ANSWER:
    assert property (setup |=> pready) else $error("no answer");
  AST_READY_CAUSE:
    assert property (pready |-> $past(setup)) else $error("stray ready");
  AST_BAD_ADDR:
    assert property (pready && bad |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  AST_QUIET:
    assert property ($fell(rst) |-> (o == 3'h0) [*2])
    else $error("output active after reset");
  AST_PER_PULSE:
    assert property (o[1] != pol_reg[1] && pol_reg == pold_reg |=>
      o[1] == pol_reg[1] || pol_reg != pold_reg) else $error("wide pulse");
  AST_POL_RD:
    assert property (rd && paddr == ATCO_OFS_CTRL1 |->
      prdata[3:1] == pol_reg) else $error("polarity lost");
  AST_MISS_HIGH:
    assert property (rd && paddr == ATCO_OFS_MISS_HIGH |->
      prdata[7:0] == hi_reg) else $error("held byte lost");
  AST_MISS_LOW:
    assert property (rd && paddr == ATCO_OFS_MISS_LOW |->
      prdata[7:0] == lo_reg) else $error("low byte wrong");
endmodule

// File: sim/atco_top_tb.sv
module atco_top_tb
  import atco_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic er;
  } atco_row_t;
  localparam atco_row_t REGS[5] = '{
    '{ATCO_OFS_CLK_SEL, 32'h1, 32'h1, 1'h0},
    '{ATCO_OFS_CTRL0, 32'h83, 32'h83, 1'h0},
    '{ATCO_OFS_SIG_SEL, 32'h3, 32'h3, 1'h0},
    '{ATCO_OFS_CTRL1, 32'hF, 32'hE, 1'h0},
    '{8'h40, 32'h5A, 32'h0, 1'h1}};
  // Rows: clock source, prescale, channel
  localparam int MEAS[5][3] = '{'{0, 0, 0}, '{0, 1, 1}, '{0, 2, 2},
    '{0, 3, 3}, '{1, 0, 3}};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic drop = 1'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, fast_osc_in;
  logic phase_clock_out, period_clock_out, missed_pulse_out;
  logic [3:0] sig_in;
  logic [2:0] o;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int k;
  assign o = {phase_clock_out, period_clock_out, missed_pulse_out};
  always #50 clk = ~clk;
  atco_top #(.NUM_SIG(4), .CNT_W(16)) DUT (.clk, .rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .fast_osc_in,
    .sig_in, .phase_clock_out, .period_clock_out, .missed_pulse_out);
  atco_sig_model u_src (.clk, .rst, .drop, .sig(sig_in),
    .osc(fast_osc_in));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, s, x);
    end
  endtask
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  // Edges until an output reaches a level, capped at 1000
  task automatic wt(input int i, input logic lv);
    k = 0;
    while (o[i] !== lv && k < 1000)
    begin
      @(posedge clk);
      k++;
    end
  endtask
  // Restart the timer and poll until it reports valid
  task automatic cfg(input int s, input int ps, input int c);
    apb(ATCO_OFS_CLK_SEL, 1'h1, 32'(s));
    apb(ATCO_OFS_SIG_SEL, 1'h1, 32'(c));
    apb(ATCO_OFS_CTRL0, 1'h1, 32'h0);
    apb(ATCO_OFS_CTRL0, 1'h1, 32'h80 | 32'(ps));
    // Stale read data must not end the poll before a real status read
    r = 32'h0;
    for (int i = 0; i < 200 && r[ATCO_VALID_BIT] !== 1'h1; i++)
    begin
      repeat (20) @(posedge clk);
      apb(ATCO_OFS_CTRL1, 1'h0, 32'h0);
    end
  endtask
  // Skip a pulse that may close a stretched period, then drop teeth
  task automatic mt(input int lo, input int hi);
    wt(1, 1'h1);
    @(posedge clk);
    wt(1, 1'h1);
    drop <= 1'h1;
    wt(0, 1'h1);
    drop <= 1'h0;
    chk(k >= lo && k <= hi, 1'h1);
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_fail++;
      conclude;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      apb(ATCO_OFS_CTRL1 + 8'(4 * i), 1'h0, 32'h0);
      chk(r, 32'h0);
    end
    foreach (REGS[i])
    begin
      apb(REGS[i].a, 1'h1, REGS[i].d);
      apb(REGS[i].a, 1'h0, 32'h0);
      chk(r, REGS[i].x);
      chk(e, REGS[i].er);
    end
    apb(ATCO_OFS_CTRL1, 1'h1, 32'h0);
    foreach (MEAS[i])
    begin
      cfg(MEAS[i][0], MEAS[i][1], MEAS[i][2]);
      apb(ATCO_OFS_PERIOD, 1'h0, 32'h0);
      chk((r[15:0] + 32'h1) >> 1, ((64 * (MEAS[i][2] + 1)) >>
        MEAS[i][1]) / (MEAS[i][0] ? 8 : 1) / 2);
    end
    cfg(0, 0, 0);
    for (int p = 0; p < 2; p++)
    begin
      apb(ATCO_OFS_CTRL1, 1'h1, p ? 32'hE : 32'h0);
      // Let the old idle level drain so it cannot pose as a pulse
      repeat (2) @(posedge clk);
      wt(2, ~p[0]);
      chk(k < 1000, 1'h1);
      wt(1, ~p[0]);
      chk(k < 1000, 1'h1);
      chk(missed_pulse_out, p[0]);
    end
    apb(ATCO_OFS_CTRL1, 1'h1, 32'h0);
    apb(ATCO_OFS_MISS_HIGH, 1'h1, 32'h0);
    apb(ATCO_OFS_MISS_LOW, 1'h1, 32'h4);
    apb(ATCO_OFS_MISS_HIGH, 1'h1, 32'h1);
    apb(ATCO_OFS_MISS_HIGH, 1'h0, 32'h0);
    chk(r, 32'h1);
    apb(ATCO_OFS_MISS_LOW, 1'h0, 32'h0);
    chk(r, 32'h4);
    mt(64, 72);
    apb(ATCO_OFS_MISS_LOW, 1'h1, 32'h4);
    mt(320, 328);
    apb(ATCO_OFS_CTRL1, 1'h1, 32'hE);
    apb(ATCO_OFS_CTRL0, 1'h1, 32'h0);
    repeat (8) @(posedge clk);
    chk(o, 3'h7);
    apb(ATCO_OFS_CTRL1, 1'h0, 32'h0);
    chk(r, 32'hE);
    // Reset after disable: outputs and settings return to their reset state
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(o, 3'h0);
    apb(ATCO_OFS_CTRL0, 1'h0, 32'h0);
    chk(r, 32'h0);
    conclude;
  end
endmodule
bind atco_top atco_top_asserts u_chk (.clk, .rst, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .phase_clock_out,
  .period_clock_out, .missed_pulse_out);
